/* hw/crod_pkg.sv */
// types shared by the can remote/overload/debug block
`default_nettype none
package crod_pkg;
  // bus field reported by the protocol engine
  typedef enum logic [2:0] {
    fld_other, fld_idle, fld_interm, fld_eof, fld_delim
  } crod_field_e;
  // debug mode sequencer
  typedef enum logic [2:0] {
    frz_run, frz_wait_bus, frz_wait_act, frz_frozen, frz_resync
  } crod_frz_e;
endpackage : crod_pkg
`default_nettype wire

/* hw/crod_prescaler.sv */
// bit-time prescaler producing one-cycle sample enables
`default_nettype none
module crod_prescaler #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] div,
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } crod_psc_s;
  crod_psc_s s_reg;
  crod_psc_s s_next;

  // count up from zero to div, tick on wrap; held cleared while disabled
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!en) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt >= div) begin
      s_next.cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule : crod_prescaler
`default_nettype wire

/* hw/crod_regs.svh */
// register map, field positions, reset values and timing counts of the can remote/overload/debug block
// Summary of operation
// - a received remote frame is never stored; it only triggers a response
// - remote frame matching a response-enabled transmit buffer starts that buffer's transmission
// - acceptance masks play no part in remote frame identifier matching
// - every identifier bit except rtr must equal the buffer's bit to match
// - overload frames are sent only on the listed bus conditions
// - dominant sample in first or second intermission bit sends an overload frame
// - dominant sample in last end-of-frame bit while receiving sends an overload frame
// - dominant sample in last error or overload delimiter bit sends an overload frame
// - debug request comes from the halt bit or the freeze line
// - debug requests count only while the entry permit bit is set
// - entry waits for intermission, idle, error passive or bus off
// - after that, entry waits until all internal activity has finished
// - in debug mode frames stop and the bit-time prescaler is disabled
// - in debug mode receive input is ignored and transmit held recessive
// - on entry synchronization is dropped, not-ready and acknowledge bits set
// - error counters are writable only while in debug mode
// - debug mode ends when freeze line is negated and halt bit is clear, or when the permit bit is cleared
`ifndef CROD_REGS_SVH
`define CROD_REGS_SVH
`define CROD_ADDR_MCR 8'h00
`define CROD_ADDR_PRESDIV 8'h04
`define CROD_ADDR_TEC 8'h08
`define CROD_ADDR_REC 8'h0C
`define CROD_ADDR_BUF0 8'h10
`define CROD_MCR_HALT_BIT 0
`define CROD_MCR_PERMIT_BIT 1
`define CROD_MCR_MODULE_NOT_READY_BIT 4
`define CROD_MCR_ACK_BIT 5
`define CROD_BUF_IDE_BIT 29
`define CROD_BUF_RR_BIT 31
`define CROD_RST_HALT 1'h0
`define CROD_RST_PERMIT 1'h0
`define CROD_RST_PRESDIV 8'h00
`define CROD_RST_ERRCNT 8'h00
`define CROD_RESYNC_BITS 4'hB
`endif

/* hw/crod_remote_match.sv */
// identifier comparison of a remote frame against the transmit buffers
`include "crod_regs.svh"
`default_nettype none
module crod_remote_match #(
  parameter int NBUF = 4,
  parameter int IW = 2
) (
  input wire logic [NBUF-1:0][31:0] bufs,
  input wire logic [28:0] rx_id,
  input wire logic rx_ide,
  output logic hit,
  output logic [IW-1:0] idx
);
  logic [NBUF-1:0] match;

  // full identifier compare per buffer, no mask applied
  for (genvar i = 0; i < NBUF; i++) begin : g_cmp
    assign match[i] = bufs[i][`CROD_BUF_RR_BIT] &&
                      (bufs[i][`CROD_BUF_IDE_BIT] == rx_ide) &&
                      (bufs[i][28:0] == rx_id);
  end

  // lowest matching buffer wins
  always_comb begin
    hit = 1'b0;
    idx = '0;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit = 1'b1;
        idx = IW'(i);
      end
    end
  end
endmodule : crod_remote_match
`default_nettype wire

/* hw/crod_top.sv */
// can remote response, overload trigger and debug mode control with apb registers
`include "crod_regs.svh"
`default_nettype none
module crod_top
  import crod_pkg::*;
#(
  parameter int NBUF = 4,
  parameter int IW = (NBUF > 1) ? $clog2(NBUF) : 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic intermodule_bus_freeze,
  input wire logic can_rx,
  output logic can_tx,
  input wire logic pe_tx,
  output logic pe_rx,
  output logic bit_tick,
  input wire crod_field_e pe_field,
  input wire logic [3:0] pe_bit_idx,
  input wire logic pe_receiving,
  input wire logic pe_busy,
  input wire logic err_passive,
  input wire logic bus_off,
  input wire logic rx_done,
  input wire logic [28:0] rx_id,
  input wire logic rx_ide,
  input wire logic rx_rtr,
  input wire logic [7:0] tec_in,
  input wire logic [7:0] rec_in,
  output logic rx_store,
  output logic resp_req,
  output logic [IW-1:0] resp_idx,
  output logic ovld_req,
  output logic module_not_ready,
  output logic debug_entry_acknowledge,
  output logic [7:0] err_cnt_tx,
  output logic [7:0] err_cnt_rx,
  output logic err_cnt_load
);
  typedef struct packed {
    crod_frz_e st;
    logic halt;
    logic permit;
    logic not_ready;
    logic ack;
    logic [7:0] presdiv;
    logic [7:0] tec;
    logic [7:0] rec;
    logic cnt_load;
    logic [3:0] resync_cnt;
    logic [NBUF-1:0][31:0] bufs;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx;
    logic rx;
    logic rx_store;
    logic resp_req;
    logic [IW-1:0] resp_idx;
    logic ovld_req;
  } crod_top_s;

  crod_top_s s_reg;
  crod_top_s s_next;
  logic hit;
  logic [IW-1:0] hit_idx;
  logic tick;
  logic frozen;
  logic req;
  logic bus_cond;
  logic setup;
  logic wr;
  logic mapped;
  logic buf_sel;
  logic [IW-1:0] buf_idx;
  logic dominant;

  // remote frame identifier matcher
  crod_remote_match #(.NBUF(NBUF), .IW(IW)) u_match (
    .bufs(s_reg.bufs),
    .rx_id(rx_id),
    .rx_ide(rx_ide),
    .hit(hit),
    .idx(hit_idx)
  );

  // bit-time prescaler, stopped while frozen
  crod_prescaler #(.W(8)) u_psc (
    .clk(pclk),
    .rst_n(presetn),
    .en(s_reg.st != frz_frozen),
    .div(s_reg.presdiv),
    .tick(tick)
  );

  // request, entry condition and bus decode terms
  assign frozen = (s_reg.st == frz_frozen);
  assign req = s_reg.permit && (s_reg.halt || intermodule_bus_freeze);
  assign bus_cond = (pe_field == fld_interm) || (pe_field == fld_idle) ||
                    err_passive || bus_off;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && s_reg.pready;
  assign buf_sel = (paddr >= `CROD_ADDR_BUF0) &&
                   (paddr < 8'(`CROD_ADDR_BUF0 + 4 * NBUF)) && (paddr[1:0] == 2'h0);
  assign buf_idx = IW'((paddr - `CROD_ADDR_BUF0) >> 2);
  assign mapped = buf_sel || (paddr == `CROD_ADDR_MCR) || (paddr == `CROD_ADDR_PRESDIV) ||
                  (paddr == `CROD_ADDR_TEC) || (paddr == `CROD_ADDR_REC);
  assign dominant = !can_rx;

  // next state of the whole block
  always_comb begin
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.cnt_load = 1'b0;
    s_next.rx_store = 1'b0;
    s_next.resp_req = 1'b0;
    s_next.ovld_req = 1'b0;
    // apb setup: answer next cycle with registered read data
    if (setup) begin
      s_next.pready = 1'b1;
      s_next.pslverr = !mapped;
      s_next.prdata = 32'h0000_0000;
      if (buf_sel) begin
        s_next.prdata = s_reg.bufs[buf_idx];
      end else begin
        case (paddr)
          `CROD_ADDR_MCR: begin
            s_next.prdata[`CROD_MCR_HALT_BIT] = s_reg.halt;
            s_next.prdata[`CROD_MCR_PERMIT_BIT] = s_reg.permit;
            s_next.prdata[`CROD_MCR_MODULE_NOT_READY_BIT] = s_reg.not_ready;
            s_next.prdata[`CROD_MCR_ACK_BIT] = s_reg.ack;
          end
          `CROD_ADDR_PRESDIV: s_next.prdata[7:0] = s_reg.presdiv;
          `CROD_ADDR_TEC: s_next.prdata[7:0] = s_reg.tec;
          `CROD_ADDR_REC: s_next.prdata[7:0] = s_reg.rec;
          default: s_next.prdata = 32'h0000_0000;
        endcase
      end
    end
    // error counters follow the engine outside debug mode
    if (!frozen) begin
      s_next.tec = tec_in;
      s_next.rec = rec_in;
    end
    // apb write in the access cycle
    if (wr) begin
      if (buf_sel) begin
        s_next.bufs[buf_idx] = pwdata;
      end else begin
        case (paddr)
          `CROD_ADDR_MCR: begin
            s_next.halt = pwdata[`CROD_MCR_HALT_BIT];
            s_next.permit = pwdata[`CROD_MCR_PERMIT_BIT];
          end
          `CROD_ADDR_PRESDIV: s_next.presdiv = pwdata[7:0];
          `CROD_ADDR_TEC: begin
            if (frozen) begin
              s_next.tec = pwdata[7:0];
              s_next.cnt_load = 1'b1;
            end
          end
          `CROD_ADDR_REC: begin
            if (frozen) begin
              s_next.rec = pwdata[7:0];
              s_next.cnt_load = 1'b1;
            end
          end
          default: s_next.cnt_load = 1'b0;
        endcase
      end
    end
    // received frames: data frames to storage, remote frames to the response path
    if (rx_done && !frozen) begin
      s_next.rx_store = !rx_rtr;
      if (rx_rtr && hit) begin
        s_next.resp_req = 1'b1;
        s_next.resp_idx = hit_idx;
      end
    end
    // overload detection at each bit sample point
    if (tick && !frozen && dominant) begin
      if ((pe_field == fld_interm) && (pe_bit_idx < 4'h2)) begin
        s_next.ovld_req = 1'b1;
      end
      if ((pe_field == fld_eof) && (pe_bit_idx == 4'h6) && pe_receiving) begin
        s_next.ovld_req = 1'b1;
      end
      if ((pe_field == fld_delim) && (pe_bit_idx == 4'h7)) begin
        s_next.ovld_req = 1'b1;
      end
    end
    // pins: recessive out and idle in while frozen
    s_next.tx = frozen ? 1'b1 : pe_tx;
    s_next.rx = frozen ? 1'b1 : can_rx;
    // debug mode sequencer
    case (s_reg.st)
      frz_run: begin
        if (req) begin
          s_next.st = frz_wait_bus;
        end
      end
      frz_wait_bus: begin
        if (!req) begin
          s_next.st = frz_run;
        end else if (bus_cond) begin
          s_next.st = frz_wait_act;
        end
      end
      frz_wait_act: begin
        if (!req) begin
          s_next.st = frz_run;
        end else if (!pe_busy) begin
          s_next.st = frz_frozen;
          s_next.ack = 1'b1;
          s_next.not_ready = 1'b1;
        end
      end
      frz_frozen: begin
        if (!req) begin
          s_next.st = frz_resync;
          s_next.ack = 1'b0;
          s_next.resync_cnt = 4'h0;
        end
      end
      frz_resync: begin
        if (req) begin
          s_next.st = frz_wait_bus;
        end else if (tick) begin
          if (dominant) begin
            s_next.resync_cnt = 4'h0;
          end else if (s_reg.resync_cnt == `CROD_RESYNC_BITS - 4'h1) begin
            s_next.st = frz_run;
            s_next.not_ready = 1'b0;
            s_next.resync_cnt = 4'h0;
          end else begin
            s_next.resync_cnt = s_reg.resync_cnt + 4'h1;
          end
        end
      end
      default: s_next.st = frz_run;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= frz_run;
      s_reg.halt <= `CROD_RST_HALT;
      s_reg.permit <= `CROD_RST_PERMIT;
      s_reg.presdiv <= `CROD_RST_PRESDIV;
      s_reg.tec <= `CROD_RST_ERRCNT;
      s_reg.rec <= `CROD_RST_ERRCNT;
      s_reg.tx <= 1'b1;
      s_reg.rx <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flops
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign can_tx = s_reg.tx;
  assign pe_rx = s_reg.rx;
  assign bit_tick = tick;
  assign rx_store = s_reg.rx_store;
  assign resp_req = s_reg.resp_req;
  assign resp_idx = s_reg.resp_idx;
  assign ovld_req = s_reg.ovld_req;
  assign module_not_ready = s_reg.not_ready;
  assign debug_entry_acknowledge = s_reg.ack;
  assign err_cnt_tx = s_reg.tec;
  assign err_cnt_rx = s_reg.rec;
  assign err_cnt_load = s_reg.cnt_load;

  // checks on the block's own outputs
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  store_no_remote_a: assert property (rx_done && rx_rtr |=> !rx_store)
    else $error("remote frame was stored");
  remote_resp_a: assert property (rx_done && rx_rtr && hit && !frozen |=> resp_req)
    else $error("matching remote frame got no response");
  resp_match_a: assert property (resp_req |-> $past(rx_done && rx_rtr) &&
    (s_reg.bufs[resp_idx][28:0] == $past(rx_id)) &&
    s_reg.bufs[resp_idx][`CROD_BUF_RR_BIT])
    else $error("response from non-matching buffer");
  ovld_interm_a: assert property (tick && !frozen && dominant && pe_field == fld_interm &&
    pe_bit_idx < 4'h2 |=> ovld_req)
    else $error("intermission overload missed");
  ovld_cause_a: assert property (ovld_req |-> $past(tick && dominant && !frozen))
    else $error("overload without dominant sample");
  permit_gate_a: assert property (s_reg.st == frz_run && !s_reg.permit |=>
    s_reg.st == frz_run)
    else $error("debug entry without permit");
  entry_wait_a: assert property (s_reg.st == frz_wait_bus && !bus_cond |=>
    s_reg.st != frz_frozen)
    else $error("entry before bus condition");
  act_wait_a: assert property (s_reg.st == frz_wait_act && pe_busy && req |=>
    s_reg.st == frz_wait_act)
    else $error("entry while engine busy");
  frozen_flags_a: assert property (frozen |-> s_reg.ack && s_reg.not_ready)
    else $error("frozen without acknowledge flags");
  tx_recessive_a: assert property (frozen |=> can_tx && pe_rx)
    else $error("pins not recessive while frozen");
  psc_stop_a: assert property (frozen ##1 frozen |-> !bit_tick)
    else $error("prescaler ran while frozen");
  cnt_guard_a: assert property (!frozen |=> err_cnt_tx == $past(tec_in))
    else $error("error counter changed outside debug mode");
  exit_clear_a: assert property (frozen && !req |=> !s_reg.ack &&
    s_reg.st == frz_resync)
    else $error("debug mode not left");

  enter_c: cover property (s_reg.st == frz_wait_act ##1 frozen);
  resync_c: cover property (s_reg.st == frz_resync ##1 s_reg.st == frz_run);
  resp_c: cover property (resp_req);
  ovld_c: cover property (ovld_req);
endmodule : crod_top
`default_nettype wire

/* verification/crod_partner.sv */
// far can node: adds a dominant level on command over the wired-and bus
`default_nettype none
module crod_partner (
  input wire logic can_tx,
  input wire logic dom_req,
  output logic can_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  // dominant wins over recessive on the shared wire
  assign can_rx = can_tx & ~dom_req;
endmodule : crod_partner
`default_nettype wire

/* verification/crod_top_bench.sv */
// self-checking bench of the can remote/overload/debug block
`include "crod_regs.svh"
`default_nettype none
module crod_top_bench
  import crod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frz, pe_tx, pe_rx, tick;
  logic rcv, busy, rx_done, rx_ide, rx_rtr, dom_req, can_rx, can_tx, store, resp, ovld;
  logic nrdy, ack, ld, epass, boff;
  logic [7:0] paddr, tec_in, rec_in, c_tx, c_rx;
  logic [31:0] pwdata, prdata, rnd;
  logic [28:0] rx_id;
  logic [3:0] bidx;
  logic [1:0] ridx;
  crod_field_e fld;
  logic [32:0] q_rd[$];
  logic [4:0] q_ev[$];
  int n_fail, checks_done;

  crod_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .intermodule_bus_freeze(frz), .can_rx(can_rx), .can_tx(can_tx),
    .pe_tx(pe_tx), .pe_rx(pe_rx), .bit_tick(tick), .pe_field(fld), .pe_bit_idx(bidx),
    .pe_receiving(rcv), .pe_busy(busy), .err_passive(epass), .bus_off(boff),
    .rx_done(rx_done), .rx_id(rx_id), .rx_ide(rx_ide), .rx_rtr(rx_rtr), .tec_in(tec_in),
    .rec_in(rec_in), .rx_store(store), .resp_req(resp), .resp_idx(ridx), .ovld_req(ovld),
    .module_not_ready(nrdy), .debug_entry_acknowledge(ack), .err_cnt_tx(c_tx),
    .err_cnt_rx(c_rx), .err_cnt_load(ld));
  crod_partner peer (.can_tx(can_tx), .dom_req(dom_req), .can_rx(can_rx));

  // 50 mhz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task hang;
    n_fail++;
    report_and_stop;
  endtask : hang

  task chk_rd(input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] apb read exp %h got %h", e, g);
    end
  endtask : chk_rd

  task chk_ev(input logic [4:0] e, input logic [4:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] frame event exp %h got %h", e, g);
    end
  endtask : chk_ev

  task chk_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask : chk_bit

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [32:0] e);
    q_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task rxf(input logic [28:0] id, input logic ide, input logic rtr, input logic [4:0] e);
    if (e != 5'h00) q_ev.push_back(e);
    @(posedge pclk);
    rx_done <= 1'b1;
    rx_id <= id;
    rx_ide <= ide;
    rx_rtr <= rtr;
    @(posedge pclk);
    rx_done <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : rxf

  task ovl(input crod_field_e f, input logic [3:0] i, input logic r, input logic e);
    if (e) q_ev.push_back(5'h08);
    @(posedge pclk);
    fld <= f;
    bidx <= i;
    rcv <= r;
    dom_req <= 1'b1;
    @(posedge pclk);
    dom_req <= 1'b0;
    fld <= fld_other;
    repeat (3) @(posedge pclk);
  endtask : ovl

  task wait_ack(input logic v);
    int n;
    n = 0;
    while (ack !== v && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) hang;
    checks_done++;
  endtask : wait_ack

  // monitor: each result takes the oldest note
  always @(posedge pclk) begin
    if ((psel & penable & pready & ~pwrite) === 1'b1) begin
      chk_rd((q_rd.size() > 0) ? q_rd.pop_front() : 33'h0, {pslverr, prdata});
    end
    if ((store | resp | ovld) !== 1'b0) begin
      // index only means something alongside a response request
      chk_ev((q_ev.size() > 0) ? q_ev.pop_front() : 5'h00,
        {store, ovld, resp, ridx & {2{resp}}});
    end
  end

  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; frz = 1'b0; pe_tx = 1'b1; fld = fld_other; bidx = 4'h0; rcv = 1'b0;
    busy = 1'b1; rx_done = 1'b0; rx_id = 29'h0; rx_ide = 1'b0; rx_rtr = 1'b0;
    tec_in = 8'h00; rec_in = 8'h00; dom_req = 1'b0; rnd = 32'h0000_005F; n_fail = 0;
    checks_done = 0;
    epass = 1'b0;
    boff = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CROD_ADDR_MCR, 33'h0); // flags clear
    rd(8'h40, 33'h1_0000_0000);
    $display("reset test done");
    rnd = xs(rnd);
    apb(1'b1, `CROD_ADDR_BUF0, {3'b000, rnd[28:0]});
    apb(1'b1, `CROD_ADDR_BUF0 + 8'h04, {3'b100, rnd[28:0]});
    rxf(rnd[28:0], 1'b0, 1'b1, 5'h05); // answered not stored
    rxf(rnd[28:0] ^ 29'h1, 1'b0, 1'b1, 5'h00); // one id bit off
    rxf(rnd[28:0], 1'b1, 1'b1, 5'h00); // format bit off
    rxf(rnd[28:0], 1'b0, 1'b0, 5'h10); // data frame stored
    $display("remote test done");
    apb(1'b1, `CROD_ADDR_PRESDIV, 32'h0);
    ovl(fld_interm, 4'h0, 1'b0, 1'b1);
    ovl(fld_interm, 4'h1, 1'b0, 1'b1);
    ovl(fld_interm, 4'h2, 1'b0, 1'b0);
    ovl(fld_eof, 4'h6, 1'b1, 1'b1);
    ovl(fld_eof, 4'h6, 1'b0, 1'b0);
    ovl(fld_delim, 4'h7, 1'b0, 1'b1);
    ovl(fld_delim, 4'h6, 1'b0, 1'b0);
    ovl(fld_idle, 4'h0, 1'b0, 1'b0);
    $display("overload test done");
    rnd = xs(rnd);
    tec_in <= rnd[7:0];
    rec_in <= rnd[15:8];
    apb(1'b1, `CROD_ADDR_TEC, 32'hA5);
    rd(`CROD_ADDR_TEC, {25'h0, rnd[7:0]}); // write ignored when running
    apb(1'b1, `CROD_ADDR_MCR, 32'h1);
    repeat (8) @(posedge pclk);
    rd(`CROD_ADDR_MCR, 33'h1); // no entry without permit
    apb(1'b1, `CROD_ADDR_MCR, 32'h3);
    repeat (8) @(posedge pclk);
    rd(`CROD_ADDR_MCR, 33'h3); // bus still busy
    fld <= fld_idle;
    repeat (8) @(posedge pclk);
    rd(`CROD_ADDR_MCR, 33'h3); // engine still active
    busy <= 1'b0;
    wait_ack(1'b1); // poll before other access
    rd(`CROD_ADDR_MCR, 33'h33);
    pe_tx <= 1'b0;
    dom_req <= 1'b1;
    fld <= fld_interm;
    repeat (4) @(posedge pclk);
    chk_bit("can_tx", 1'b1, can_tx);
    chk_bit("pe_rx", 1'b1, pe_rx);
    chk_bit("bit_tick", 1'b0, tick);
    chk_bit("module_not_ready", 1'b1, nrdy);
    dom_req <= 1'b0;
    pe_tx <= 1'b1;
    fld <= fld_other;
    apb(1'b1, `CROD_ADDR_TEC, {24'h0, ~rnd[7:0]});
    @(posedge pclk);
    chk_bit("err_cnt_load", 1'b1, ld);
    chk_bit("err_cnt_tx", 1'b1, c_tx == ~rnd[7:0]);
    chk_bit("err_cnt_rx", 1'b1, c_rx == rnd[15:8]);
    rd(`CROD_ADDR_TEC, {25'h0, ~rnd[7:0]});
    apb(1'b1, `CROD_ADDR_MCR, 32'h2);
    wait_ack(1'b0);
    rd(`CROD_ADDR_MCR, 33'h12); // still resyncing
    repeat (20) @(posedge pclk);
    rd(`CROD_ADDR_MCR, 33'h2);
    // freeze line entry, bus condition given by error passive alone
    epass <= 1'b1;
    frz <= 1'b1;
    wait_ack(1'b1);
    rd(`CROD_ADDR_MCR, 33'h32);
    frz <= 1'b0;
    epass <= 1'b0;
    wait_ack(1'b0);
    apb(1'b1, `CROD_ADDR_MCR, 32'h0);
    // freeze line and bus off without permit: no entry, resync long done
    frz <= 1'b1;
    boff <= 1'b1;
    repeat (12) @(posedge pclk);
    rd(`CROD_ADDR_MCR, 33'h0);
    frz <= 1'b0;
    boff <= 1'b0;
    $display("debug test done");
    repeat (4) @(posedge pclk);
    chk_bit("notes used", 1'b1, q_rd.size() == 0 && q_ev.size() == 0);
    report_and_stop;
  end
endmodule : crod_top_bench
`default_nettype wire
